/* cgt_params.svh */
// constants for the clock generator trim and status block
`ifndef CGT_PARAMS_SVH
`define CGT_PARAMS_SVH
`define CGT_ADDR_TRIM      4'h0
`define CGT_ADDR_SC        4'h1
`define CGT_ADDR_CTRL      4'h2
`define CGT_ADDR_SEL       4'h3
`define CGT_TRIM_RST       8'h80
`define CGT_BIT_LOST       7
`define CGT_BIT_LOCK       6
`define CGT_BIT_LOOPST     5
`define CGT_BIT_REFST      4
`define CGT_BIT_CLOCK_MODE_STATUS_HI   3
`define CGT_BIT_CLOCK_MODE_STATUS_LO   2
`define CGT_BIT_OSCRDY     1
`define CGT_BIT_FINE       0
`define CGT_CTRL_IRQEN     7
`define CGT_CTRL_LOOP      6
`define CGT_CTRL_LOWPWR    3
`define CGT_CTRL_OSCREQ    2
`define CGT_CTRL_EXTEN     1
`define CGT_SEL_SRC        7:6
`define CGT_SEL_DIV        5:3
`define CGT_SEL_REF        2
`define CGT_SEL_MUL        1:0
`define CGT_MUL_RST        4'h1
`define CGT_SRC_RSVD_CODE  2'h3
`define CGT_OSC_INIT_CYC   16'h1000
`define CGT_SYNC_STAGES    2
`endif

/* cgt_pkg.sv */
// types for the clock generator trim and status block
package cgt_pkg;
    typedef enum logic [1:0] {
        CGT_SRC_LOOP,
        CGT_SRC_INT,
        CGT_SRC_EXT,
        CGT_SRC_RSVD
    } cgt_src_e;
    typedef struct packed {
        logic       reference_select;
        logic       loop_select;
        logic [2:0] reference_divider;
        logic [3:0] vco_multiplier_select;
        logic [1:0] clock_source_select;
        logic       oscillator_request;
        logic       external_ref_enable;
        logic       low_power;
    } cgt_sel_s;
endpackage

/* cgt_sync.sv */
// multi-stage level synchroniser
`timescale 1ns/1ns
module cgt_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] chain [STAGES];

    if (STAGES < 2) begin : g_bad_stages
        $error("cgt_sync needs two stages or more");
    end

    // shift chain, only last stage is read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < STAGES; i++) chain[i] <= '0;
        end else begin
            chain[0] <= d;
            for (int i = 1; i < STAGES; i++) chain[i] <= chain[i-1];
        end
    end

    assign q = chain[STAGES-1];
endmodule // cgt_sync

/* cgt_trim_status.sv */
// trim and status registers of the clock generator
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "cgt_params.svh"

// How it works
// R1 - eight bit coarse trim, binary weighted, larger value gives longer period
// R2 - fine trim bit lengthens period one least step when set
// R3 - software copies factory trim itself; nothing loads it automatically
// R4 - lost lock flag sets sticky when enabled loop loses acquired lock
// R5 - lost lock flag clears on reset or writing one; zero ignored
// R6 - interrupt request on lost lock only with interrupt enable set
// R7 - lock flag follows loop lock; detection off with both loops disabled
// R8 - select, divider, trim or multiplier changes clear lock until relock; trim only with fll on internal ref, multiplier with pll on ext ref
// R9 - stop mode entry clears lock until relocked
// R10 - low power bypass entry clears lock until exited and relocked
// R11 - loop select status reports loop in use after synchronisation
// R12 - reference status reports reference in use after synchronisation
// R13 - clock mode status encodes active output source after synchronisation
// R14 - oscillator ready sets after start-up when requested and external used
// R15 - oscillator ready clears on request removal or external unused
// R16 - interrupt enable matters only while the lost lock flag is set
// R17 - loop select picks pll when set, fll when clear
// R18 - clock source code 11 behaves as 00
// R19 - foreign domain status passes two stage synchroniser before reads
// R20 - writes to read-only status bits ignored
module cgt_trim_status
    import cgt_pkg::*;
#(
    parameter int OSC_INIT_CYC = `CGT_OSC_INIT_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       loop_locked,
    input  wire logic       loop_unlocked_out,
    input  wire logic       stop_enter,
    input  wire logic       osc_clock_seen,
    output logic      [7:0] coarse_trim,
    output logic            fine_period_adjust,
    output logic            lost_lock_irq,
    output logic            lock_detect_enable,
    output logic            pll_enable,
    output logic            fll_enable,
    output cgt_sel_s        sel_active
);
    cgt_sel_s  sel;
    logic      lost_lock_flag;
    logic      lost_lock_irq_enable;
    logic      lock_flag;
    logic      lock_valid;
    logic      locked_s;
    logic      unl_s;
    logic      osc_s;
    logic      oscillator_ready;
    logic      in_stop;
    logic      in_blp;
    logic      loop_select_status;
    logic      reference_status;
    logic [1:0] clock_mode_status;
    logic [15:0] osc_cnt;
    logic [3:0] req_bus;
    logic [3:0] req_sync;
    logic [7:0] next_rdata;
    logic      lock_kill;
    logic      wr_trim;
    logic      wr_sc;
    logic      wr_ctrl;
    logic      wr_sel;
    logic      ext_used;
    logic      int_mode;
    cgt_src_e  src_eff;

    if (OSC_INIT_CYC < 1 || OSC_INIT_CYC > 65535) begin : g_bad_osc_cyc
        $error("OSC_INIT_CYC out of range");
    end

    // address decode
    assign wr_trim = wr && addr == `CGT_ADDR_TRIM;
    assign wr_sc   = wr && addr == `CGT_ADDR_SC;
    assign wr_ctrl = wr && addr == `CGT_ADDR_CTRL;
    assign wr_sel  = wr && addr == `CGT_ADDR_SEL;

    // reserved source code folds onto loop output
    assign src_eff = (sel.clock_source_select == `CGT_SRC_RSVD_CODE) ? CGT_SRC_LOOP
                   : cgt_src_e'(sel.clock_source_select); // R18

    // unselected loop disabled in every mode
    assign in_blp   = sel.low_power && src_eff != CGT_SRC_LOOP;
    assign int_mode = sel.reference_select && src_eff != CGT_SRC_EXT;
    assign ext_used = sel.external_ref_enable || !int_mode; // R14

    // coarse trim register, software loads factory value itself
    always_ff @(posedge core_clk) begin
        if (rst) begin
            coarse_trim <= `CGT_TRIM_RST;
        end else if (wr_trim) begin
            coarse_trim <= wdata; // R1 R3
        end
    end

    // fine trim bit, only writable bit besides the lost lock clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fine_period_adjust <= 1'b0;
        end else if (wr_sc) begin
            fine_period_adjust <= wdata[`CGT_BIT_FINE]; // R2 R20
        end
    end

    // control bits: interrupt enable, request, enables, low power
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lost_lock_irq_enable    <= 1'b0;
            sel.oscillator_request  <= 1'b0;
            sel.external_ref_enable <= 1'b0;
            sel.low_power           <= 1'b0;
            sel.loop_select         <= 1'b0;
        end else if (wr_ctrl) begin
            lost_lock_irq_enable    <= wdata[`CGT_CTRL_IRQEN];
            sel.loop_select         <= wdata[`CGT_CTRL_LOOP]; // R17
            sel.oscillator_request  <= wdata[`CGT_CTRL_OSCREQ];
            sel.external_ref_enable <= wdata[`CGT_CTRL_EXTEN];
            sel.low_power           <= wdata[`CGT_CTRL_LOWPWR];
        end
    end

    // selection register: source, divider, reference, multiplier
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel.clock_source_select   <= 2'h0;
            sel.reference_divider     <= 3'h0;
            sel.reference_select      <= 1'b1;
            sel.vco_multiplier_select <= `CGT_MUL_RST;
        end else if (wr_sel) begin
            sel.clock_source_select   <= wdata[`CGT_SEL_SRC];
            sel.reference_divider     <= wdata[`CGT_SEL_DIV];
            sel.reference_select      <= wdata[`CGT_SEL_REF];
            sel.vco_multiplier_select <= {1'b0, wdata[`CGT_SEL_MUL], 1'b1};
        end
    end

    // loop enables follow loop select and bypass; lock detection follows bypass only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pll_enable         <= 1'b0;
            fll_enable         <= 1'b1;
            lock_detect_enable <= 1'b1;
            sel_active         <= '0;
        end else begin
            pll_enable         <= sel.loop_select && !in_blp; // R17
            fll_enable         <= !sel.loop_select && !in_blp; // R17
            lock_detect_enable <= !in_blp; // R7
            sel_active         <= sel;
        end
    end

    // lock inputs come from the loop domain
    cgt_sync #(
        .WIDTH  (3),
        .STAGES (`CGT_SYNC_STAGES)
    ) u_lock_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        ({loop_locked, loop_unlocked_out, osc_clock_seen}),
        .q        ({locked_s, unl_s, osc_s})
    ); // R19

    // requested selections cross to the generator domain and back
    assign req_bus = {sel.loop_select, sel.reference_select, src_eff == CGT_SRC_LOOP
                      ? 2'h0 : sel.clock_source_select};
    cgt_sync #(
        .WIDTH  (4),
        .STAGES (`CGT_SYNC_STAGES)
    ) u_sel_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (req_bus),
        .q        (req_sync)
    ); // R19

    // status of the source actually in use
    always_ff @(posedge core_clk) begin
        if (rst) begin
            loop_select_status <= 1'b0;
            reference_status   <= 1'b1;
            clock_mode_status  <= 2'h0;
        end else begin
            loop_select_status <= req_sync[3]; // R11
            reference_status   <= req_sync[2]; // R12
            if (req_sync[1:0] == 2'h0) begin
                clock_mode_status <= req_sync[3] ? 2'h3 : 2'h0; // R13
            end else begin
                clock_mode_status <= req_sync[1:0]; // R13
            end
        end
    end

    // events that force the lock flag clear
    assign lock_kill = stop_enter || in_blp
        || (wr_sel && (wdata[`CGT_SEL_REF] != sel.reference_select
                       || wdata[`CGT_SEL_DIV] != sel.reference_divider)) // R8
        || (wr_ctrl && wdata[`CGT_CTRL_LOOP] != sel.loop_select) // R8
        || (wr_trim && wdata != coarse_trim && int_mode && !sel.loop_select) // R8
        || (wr_sel && {1'b0, wdata[`CGT_SEL_MUL], 1'b1} != sel.vco_multiplier_select
            && sel.loop_select && !sel.reference_select); // R8

    // stop mode latch, released when the synchronised lock drops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_stop <= 1'b0;
        end else if (stop_enter) begin
            in_stop <= 1'b1; // R9
        end else if (!locked_s) begin
            in_stop <= 1'b0;
        end
    end

    // lock flag needs a fresh lock after any kill event
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_valid <= 1'b0;
            lock_flag  <= 1'b0;
        end else begin
            if (lock_kill) begin
                lock_valid <= 1'b0; // R8 R9 R10
            end else if (!locked_s) begin
                lock_valid <= 1'b1;
            end
            lock_flag <= lock_valid && !lock_kill && !in_stop && locked_s
                         && !in_blp; // R7 R10
        end
    end

    // sticky lost lock, set wins over a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lost_lock_flag <= 1'b0; // R5
        end else if (lock_flag && unl_s && !in_blp) begin
            lost_lock_flag <= 1'b1; // R4
        end else if (wr_sc && wdata[`CGT_BIT_LOST] && lost_lock_flag) begin
            lost_lock_flag <= 1'b0; // R5
        end
    end

    // interrupt request only while flag set and enabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lost_lock_irq <= 1'b0;
        end else begin
            lost_lock_irq <= lost_lock_flag && lost_lock_irq_enable; // R6 R16
        end
    end

    // oscillator start-up counter and ready bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_cnt          <= 16'h0;
            oscillator_ready <= 1'b0;
        end else if (!sel.oscillator_request || (int_mode && !sel.external_ref_enable)) begin
            osc_cnt          <= 16'h0;
            oscillator_ready <= 1'b0; // R15
        end else if (ext_used && osc_s && !oscillator_ready) begin
            if (osc_cnt == 16'(OSC_INIT_CYC - 1)) begin
                oscillator_ready <= 1'b1; // R14
            end else begin
                osc_cnt <= osc_cnt + 16'h1;
            end
        end
    end

    // read mux
    always_comb begin
        next_rdata = 8'h00;
        case (addr)
            `CGT_ADDR_TRIM: next_rdata = coarse_trim;
            `CGT_ADDR_SC: begin
                next_rdata = {lost_lock_flag, lock_flag, loop_select_status,
                              reference_status, clock_mode_status,
                              oscillator_ready, fine_period_adjust};
            end
            `CGT_ADDR_CTRL: begin
                next_rdata = {lost_lock_irq_enable, sel.loop_select, 2'h0,
                              sel.low_power, sel.oscillator_request,
                              sel.external_ref_enable, 1'b0};
            end
            `CGT_ADDR_SEL: begin
                next_rdata = {sel.clock_source_select, sel.reference_divider,
                              sel.reference_select, sel.vco_multiplier_select[2:1]};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // read data one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // cgt_trim_status

/* cgt_trim_status_props.sv */
// property checker for the trim and status block
`timescale 1ns/1ns
module cgt_trim_status_props #(
    parameter int OSC_INIT_CYC = 4096
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] coarse_trim,
    input wire logic       fine_period_adjust,
    input wire logic       lost_lock_irq,
    input wire logic       lock_detect_enable,
    input wire logic       pll_enable,
    input wire logic       fll_enable
);
    // single clock domain, synchronous reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_trim; wr && addr == 4'h0 |=> coarse_trim == $past(wdata); endproperty
    a_trim: assert property (p_trim) else $error("coarse trim write lost");
    property p_trim_hold; !(wr && addr == 4'h0) |=> $stable(coarse_trim); endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("coarse trim moved");
    property p_fine; wr && addr == 4'h1 |=> fine_period_adjust == $past(wdata[0]); endproperty
    a_fine: assert property (p_fine) else $error("fine trim write lost");
    property p_rd_idle; !rd |=> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_unmapped; rd && addr[3:2] != 2'b00 |=> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq; rd && addr == 4'h1 ##1 !rdata[7] |-> !lost_lock_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq without lost lock");
    property p_loops; !(pll_enable && fll_enable); endproperty
    a_loops: assert property (p_loops) else $error("both loops enabled");
    property p_det; (!pll_enable && !fll_enable) [*2] |-> !lock_detect_enable; endproperty
    a_det: assert property (p_det) else $error("lock detect with loops off");
endmodule // cgt_trim_status_props

/* cgt_trim_status_test.sv */
// self-checking bench for the trim and status block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module cgt_trim_status_test;
    import cgt_pkg::*;
    localparam int OSC_INIT_CYC = 4;
    logic       core_clk, rst, wr, rd, loop_locked, loop_unlocked_out;
    logic       stop_enter, osc_clock_seen, fine_period_adjust, lost_lock_irq;
    logic       lock_detect_enable, pll_enable, fll_enable;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, coarse_trim, rd_val;
    cgt_sel_s   sel_active;
    int         bad_count = 0;
    int         num_checks = 0;

    cgt_trim_status #(.OSC_INIT_CYC(OSC_INIT_CYC)) dut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .loop_locked(loop_locked), .loop_unlocked_out(loop_unlocked_out),
        .stop_enter(stop_enter), .osc_clock_seen(osc_clock_seen),
        .coarse_trim(coarse_trim), .fine_period_adjust(fine_period_adjust),
        .lost_lock_irq(lost_lock_irq), .lock_detect_enable(lock_detect_enable),
        .pll_enable(pll_enable), .fll_enable(fll_enable), .sel_active(sel_active));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        // one more edge so the written value has settled for checks
        @(posedge core_clk);
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        // read data stand in this cycle, taken at the edge that ends it
        @(posedge core_clk);
        rd_val = rdata;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // drop and regain lock at the detector input
    task automatic relock;
        @(posedge core_clk);
        loop_locked <= 1'b0;
        wait_clk(4);
        loop_locked <= 1'b1;
        wait_clk(8);
    endtask

    task automatic t_reset;
        rd_reg(4'h0);
        `CHK("trim reset", 8'h80, rd_val)
        rd_reg(4'h1);
        `CHK("fine reset", 1'b0, rd_val[0])
        rd_reg(4'hF);
        `CHK("unmapped", 8'h00, rd_val)
    endtask

    task automatic t_trim;
        logic [7:0] tv [3] = '{8'h00, 8'hFF, 8'h5A};
        logic [7:0] st;
        foreach (tv[i]) begin
            wr_reg(4'h0, tv[i]);
            rd_reg(4'h0);
            `CHK("trim read", tv[i], rd_val)
            `CHK("trim out", tv[i], coarse_trim)
        end
        rd_reg(4'h1);
        st = rd_val;
        wr_reg(4'h1, 8'h7F);
        rd_reg(4'h1);
        `CHK("status kept", st[6:1], rd_val[6:1])
        `CHK("fine set", 1'b1, fine_period_adjust)
        wr_reg(4'h1, 8'h00);
        `CHK("fine clear", 1'b0, fine_period_adjust)
    endtask

    // loop, reference and clock mode status per selection
    task automatic t_modes;
        logic [7:0] ctl [4] = '{8'h00, 8'h00, 8'h00, 8'h40};
        logic [7:0] sel [4] = '{8'h44, 8'h80, 8'hC4, 8'h00};
        logic [3:0] ex [4] = '{4'b0101, 4'b0010, 4'b0100, 4'b1011};
        foreach (ctl[i]) begin
            wr_reg(4'h2, ctl[i]);
            wr_reg(4'h3, sel[i]);
            wait_clk(6);
            rd_reg(4'h1);
            `CHK("mode status", ex[i], rd_val[5:2])
            `CHK("pll enable", ctl[i][6], pll_enable)
            `CHK("fll enable", !ctl[i][6], fll_enable)
            `CHK("sel copy", sel[i][7:6], sel_active.clock_source_select)
        end
    endtask

    task automatic t_lock;
        wr_reg(4'h2, 8'hC0);
        relock;
        rd_reg(4'h1);
        `CHK("locked", 1'b1, rd_val[6])
        loop_locked <= 1'b0;
        loop_unlocked_out <= 1'b1;
        wait_clk(6);
        rd_reg(4'h1);
        `CHK("lost set", 2'b10, rd_val[7:6])
        `CHK("irq on", 1'b1, lost_lock_irq)
        wr_reg(4'h1, 8'h00);
        rd_reg(4'h1);
        `CHK("lost w0", 1'b1, rd_val[7])
        loop_unlocked_out <= 1'b0;
        wr_reg(4'h1, 8'h80);
        rd_reg(4'h1);
        `CHK("lost w1", 1'b0, rd_val[7])
        `CHK("irq off", 1'b0, lost_lock_irq)
        wr_reg(4'h2, 8'h40);
        relock;
        loop_unlocked_out <= 1'b1;
        wait_clk(6);
        rd_reg(4'h1);
        `CHK("lost masked", 1'b1, rd_val[7])
        `CHK("irq masked", 1'b0, lost_lock_irq)
        loop_unlocked_out <= 1'b0;
        wr_reg(4'h1, 8'h80);
        relock;
        wr_reg(4'h3, 8'h08);
        wait_clk(6);
        rd_reg(4'h1);
        `CHK("divider kill", 1'b0, rd_val[6])
        relock;
        stop_enter <= 1'b1;
        @(posedge core_clk);
        stop_enter <= 1'b0;
        wait_clk(6);
        rd_reg(4'h1);
        `CHK("stop kill", 1'b0, rd_val[6])
        wr_reg(4'h3, 8'h40);
        relock;
        wr_reg(4'h2, 8'h48);
        wait_clk(6);
        rd_reg(4'h1);
        `CHK("bypass kill", 1'b0, rd_val[6])
        `CHK("bypass pll off", 1'b0, pll_enable)
        `CHK("bypass detect off", 1'b0, lock_detect_enable)
    endtask

    task automatic t_osc;
        wr_reg(4'h2, 8'h06);
        wr_reg(4'h3, 8'h80);
        osc_clock_seen <= 1'b1;
        wait_clk(20);
        rd_reg(4'h1);
        `CHK("osc ready", 1'b1, rd_val[1])
        wr_reg(4'h2, 8'h02);
        wait_clk(6);
        rd_reg(4'h1);
        `CHK("osc cleared", 1'b0, rd_val[1])
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        {wr, rd, stop_enter, loop_locked, loop_unlocked_out, osc_clock_seen} = 6'h00;
        addr = 4'h0;
        wdata = 8'h00;
        wait_clk(3);
        rst <= 1'b0;
        t_reset;
        t_trim;
        t_modes;
        t_lock;
        t_osc;
        finish_test;
    end

    // hang guard, far beyond the few hundred cycles used
    initial begin
        #100000;
        bad_count++;
        finish_test;
    end
endmodule // cgt_trim_status_test

bind cgt_trim_status cgt_trim_status_props #(.OSC_INIT_CYC(OSC_INIT_CYC)) u_props (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .coarse_trim(coarse_trim), .fine_period_adjust(fine_period_adjust),
    .lost_lock_irq(lost_lock_irq), .lock_detect_enable(lock_detect_enable),
    .pll_enable(pll_enable), .fll_enable(fll_enable));
